//--- hdl/reader_pin_pkg.sv
// Constants for the reader pin function and clock output block
package reader_pin_pkg;
  // Core clock and the slow host clock used while the chip sleeps
  localparam int unsigned CLOCK_HZ = 250_000_000;
  localparam int unsigned SLOW_CLOCK_HZ = 60_000;
  localparam logic [11:0] SLOW_HALF_CYCLES =
    12'(CLOCK_HZ / (2 * SLOW_CLOCK_HZ));

  // System clock setting (clock configuration register, address 0x09)
  localparam logic [7:0] HOST_SYSTEM_CLOCK_OUT_CFG_ADDR = 8'h09;
  localparam logic [1:0] HOST_SYSTEM_CLOCK_OUT_OFF = 2'h0;
  localparam logic [1:0] HOST_SYSTEM_CLOCK_OUT_DIV4 = 2'h1;
  localparam logic [1:0] HOST_SYSTEM_CLOCK_OUT_DIV2 = 2'h2;
  localparam logic [1:0] HOST_SYSTEM_CLOCK_OUT_DIV1 = 2'h3;

  // Registers that turn the modulation data terminal into an output
  localparam logic [7:0] MOD_OUT_CFG_ADDR_A = 8'h1A;
  localparam logic [7:0] MOD_OUT_CFG_ADDR_B = 8'h1B;

  // Positions in the synchronised pin vector
  localparam int SYNC_W = 14;
  localparam int IX_EN = 0;
  localparam int IX_EN2 = 1;
  localparam int IX_MODTYPE = 2;
  localparam int IX_MODDATA = 3;
  localparam int IX_DCLK = 4;
  localparam int IX_REF = 5;
  localparam int IX_IO = 6;

  // Shared data terminal roles
  localparam int IO_SSEL = 4;
  localparam int IO_BITCLK = 5;
  localparam int IO_SOUT = 6;
  localparam int IO_MOSI = 7;

  typedef enum logic [2:0] {
    SRC_OFF = 3'b000,
    SRC_DIV4 = 3'b001,
    SRC_DIV2 = 3'b010,
    SRC_DIV1 = 3'b011,
    SRC_SLOW = 3'b100
  } clk_src_t;
endpackage : reader_pin_pkg

//--- hdl/reader_pin_function_and_clock_out.sv
// Terminal function multiplexer and host system clock output
//
// How it works
// [R1] In direct modes 0 and 1 the modulation-type pin is a host input, low for ASK and high for OOK.
// [R2] When configured as output the modulation-type pin shows the received signal instead.
// [R3] In direct mode 0 or 1 the modulation data pin is a host input that keys the transmitter.
// [R4] When the 0x1A/0x1B settings make it an output, the modulation data pin carries subcarrier data.
// [R5] In parallel mode all eight shared data pins are bidirectional data lines.
// [R6] In SPI mode the host drives shared pin 4 as slave select.
// [R7] In direct mode 1 shared pin 5 is driven as the bit data clock output.
// [R8] In SPI mode shared pin 6 is driven as MISO while the host holds slave select (pin 4) low.
// [R9] Shared pin 6 carries decoded bits in direct mode 1 and raw subcarrier in direct mode 0.
// [R10] In SPI mode the host drives shared pin 7 as MOSI.
// [R11] The host supplies the data clock that times every host transfer.
// [R12] With chip enable high the system clock follows the 0x09 setting: off, /4, /2 or /1.
// [R13] With chip enable low and secondary enable high the system clock runs at 60 kHz.
// [R14] Chip enable low means sleep or power-down; normal operation only while high.
// [R15] Secondary enable high selects power-down mode 2, keeping the host supply alive.
// [R16] Clock rates come from the 13.56 MHz reference by /1, /2, /4, switched without runts.
`timescale 1ns/1ps
`default_nettype none

module reader_pin_function_and_clock_out
  import reader_pin_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  // Pins
  input wire logic chipEnablePin,
  input wire logic secondary_power_select,
  input wire logic dataClockPin,
  input wire logic refClockPin,
  input wire logic modulation_type_select_in,
  output logic modulation_type_select_out,
  output logic modulation_type_select_oe,
  input wire logic modulation_data_pin_in,
  output logic modulation_data_pin_out,
  output logic modulation_data_pin_oe,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic [7:0] ioOe,
  output logic host_system_clock_out,
  // Core configuration
  input wire logic spiMode,
  input wire logic directEnable,
  input wire logic directModeOne,
  input wire logic modTypeAsOutput,
  input wire logic modDataAsOutput,
  input wire logic [1:0] sysClockSetting,
  // Core data toward the pins
  input wire logic rxSignal,
  input wire logic subcarrierData,
  input wire logic decodedBit,
  input wire logic bitClock,
  input wire logic spiMiso,
  input wire logic [7:0] parallelOut,
  input wire logic parallelDrive,
  // Pin levels toward the core
  output logic chipActive,
  output logic powerDownTwo,
  output logic modulationOok,
  output logic txKey,
  output logic [7:0] parallelIn,
  output logic spiSelect_n,
  output logic spiMosi,
  output logic dataClockRise,
  output logic dataClockFall
);

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt;
    logic [1:0] refCnt;
    logic [11:0] slowCnt;
    logic slowClk;
    clk_src_t src;
    logic sysClk;
    logic [7:0] ioOut;
    logic [7:0] ioOe;
    logic modTypeOut;
    logic modTypeOe;
    logic modOut;
    logic modOe;
    logic dclkRise;
    logic dclkFall;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [SYNC_W-1:0] pins;
  logic active;
  logic direct;
  logic refRise;
  clk_src_t want;
  logic wantLevel;

  assign pins = {ioIn, refClockPin, dataClockPin, modulation_data_pin_in,
                 modulation_type_select_in, secondary_power_select,
                 chipEnablePin};

  always_comb begin
    s_d = s_q;
    // Three stages; a change counts once stages two and three agree
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.filt[i] = s_q.sync3[i];
      end
    end

    active = s_q.filt[IX_EN]; // R14
    direct = active && directEnable;

    // Host data clock edges for the interface logic
    s_d.dclkRise = !s_q.filt[IX_DCLK] && s_d.filt[IX_DCLK]; // R11
    s_d.dclkFall = s_q.filt[IX_DCLK] && !s_d.filt[IX_DCLK]; // R11

    // Reference divider; /2 and /4 change only on reference rising edges
    refRise = !s_q.filt[IX_REF] && s_d.filt[IX_REF];
    if (refRise) begin
      s_d.refCnt = s_q.refCnt + 2'h1; // R16
    end

    // Free 60 kHz source from the core clock
    if (s_q.slowCnt == SLOW_HALF_CYCLES - 12'h001) begin
      s_d.slowCnt = 12'h000;
      s_d.slowClk = !s_q.slowClk; // R13
    end else begin
      s_d.slowCnt = s_q.slowCnt + 12'h001;
    end

    // Requested source
    if (active) begin
      case (sysClockSetting) // R12
        HOST_SYSTEM_CLOCK_OUT_DIV4: want = SRC_DIV4;
        HOST_SYSTEM_CLOCK_OUT_DIV2: want = SRC_DIV2;
        HOST_SYSTEM_CLOCK_OUT_DIV1: want = SRC_DIV1;
        default: want = SRC_OFF;
      endcase
    end else if (s_q.filt[IX_EN2]) begin
      want = SRC_SLOW; // R13
    end else begin
      want = SRC_OFF;
    end

    case (want)
      SRC_DIV4: wantLevel = s_q.refCnt[1];
      SRC_DIV2: wantLevel = s_q.refCnt[0];
      SRC_DIV1: wantLevel = s_q.filt[IX_REF];
      SRC_SLOW: wantLevel = s_q.slowClk;
      default: wantLevel = 1'b0;
    endcase

    // Switch only while both old and new clocks are low, so no runt
    if (!s_q.sysClk && !wantLevel) begin
      s_d.src = want; // R16
    end

    case (s_d.src)
      SRC_DIV4: s_d.sysClk = s_d.refCnt[1];
      SRC_DIV2: s_d.sysClk = s_d.refCnt[0];
      SRC_DIV1: s_d.sysClk = s_d.filt[IX_REF];
      SRC_SLOW: s_d.sysClk = s_d.slowClk;
      default: s_d.sysClk = 1'b0;
    endcase

    // Modulation-type pin: host input unless turned round in direct mode
    s_d.modTypeOe = direct && modTypeAsOutput; // R2
    s_d.modTypeOut = s_d.modTypeOe && rxSignal; // R2

    // Modulation data pin: output only when configured so
    s_d.modOe = active && modDataAsOutput; // R4
    s_d.modOut = s_d.modOe && subcarrierData; // R4

    // Shared data pins; nothing driven while asleep
    s_d.ioOe = 8'h00; // R14
    s_d.ioOut = 8'h00;
    if (direct) begin
      if (directModeOne) begin
        s_d.ioOe[IO_BITCLK] = 1'b1; // R7
        s_d.ioOut[IO_BITCLK] = bitClock; // R7
        s_d.ioOut[IO_SOUT] = decodedBit; // R9
      end else begin
        s_d.ioOut[IO_SOUT] = subcarrierData; // R9
      end
      s_d.ioOe[IO_SOUT] = 1'b1; // R9
    end else if (active && spiMode) begin
      // MISO drives only while the host selects us; pins 4 and 7 listen
      s_d.ioOe[IO_SOUT] = !s_q.filt[IX_IO + IO_SSEL]; // R8 R6
      s_d.ioOut[IO_SOUT] = spiMiso; // R8
    end else if (active) begin
      s_d.ioOe = {8{parallelDrive}}; // R5
      s_d.ioOut = parallelOut; // R5
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign modulation_type_select_out = s_q.modTypeOut;
  assign modulation_type_select_oe = s_q.modTypeOe;
  assign modulation_data_pin_out = s_q.modOut;
  assign modulation_data_pin_oe = s_q.modOe;
  assign ioOut = s_q.ioOut;
  assign ioOe = s_q.ioOe;
  assign host_system_clock_out = s_q.sysClk;
  assign chipActive = s_q.filt[IX_EN]; // R14
  assign powerDownTwo = !s_q.filt[IX_EN] && s_q.filt[IX_EN2]; // R15
  assign modulationOok = directEnable && s_q.filt[IX_MODTYPE]; // R1
  // Transmit key follows the host level only in direct mode
  assign txKey = directEnable && !modDataAsOutput
                 && s_q.filt[IX_MODDATA]; // R3
  assign parallelIn = s_q.filt[IX_IO +: 8]; // R5
  assign spiSelect_n = s_q.filt[IX_IO + IO_SSEL]; // R6
  assign spiMosi = s_q.filt[IX_IO + IO_MOSI]; // R10
  assign dataClockRise = s_q.dclkRise;
  assign dataClockFall = s_q.dclkFall;

  // Checks
  a_sleep_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    !s_q.filt[IX_EN] |=> (ioOe == 8'h00) && !modulation_data_pin_oe
      && !modulation_type_select_oe) // R14
    else $error("pins driven while asleep");

  a_spi_miso: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && !directEnable && spiMode
      && !s_q.filt[IX_IO + IO_SSEL])
    |=> ioOe == 8'h40 && ioOut[IO_SOUT] == $past(spiMiso)) // R8
    else $error("miso not driven when selected");

  a_bit_clock: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && directEnable && directModeOne)
    |=> ioOe == 8'h60 && ioOut[IO_BITCLK] == $past(bitClock)
      && ioOut[IO_SOUT] == $past(decodedBit)) // R7
    else $error("direct mode 1 outputs wrong");

  a_raw_subcarrier: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && directEnable && !directModeOne)
    |=> ioOe == 8'h40 && ioOut[IO_SOUT] == $past(subcarrierData)) // R9
    else $error("direct mode 0 output wrong");

  a_parallel_bus: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && !directEnable && !spiMode && parallelDrive)
    |=> ioOe == 8'hFF && ioOut == $past(parallelOut)) // R5
    else $error("parallel bus not driven");

  a_mod_output: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && modDataAsOutput)
    |=> modulation_data_pin_oe
      && modulation_data_pin_out == $past(subcarrierData)) // R4
    else $error("mod pin output wrong");

  a_modtype_out: assert property (@(posedge clock) disable iff (!arst_n)
    (s_q.filt[IX_EN] && directEnable && modTypeAsOutput)
    |=> modulation_type_select_oe
      && modulation_type_select_out == $past(rxSignal)) // R2
    else $error("modulation type output wrong");

  a_clock_off: assert property (@(posedge clock) disable iff (!arst_n)
    (!s_q.filt[IX_EN] && !s_q.filt[IX_EN2] && s_q.src == SRC_OFF)
    |=> !host_system_clock_out) // R13
    else $error("system clock runs while off");

  a_slow_select: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(s_q.src == SRC_SLOW) |-> $past(!s_q.filt[IX_EN])
      && $past(s_q.filt[IX_EN2])) // R13
    else $error("slow clock chosen wrongly");

  a_no_runt: assert property (@(posedge clock) disable iff (!arst_n)
    $changed(s_q.src) |-> !$past(host_system_clock_out)) // R16
    else $error("clock source switched while high");

endmodule : reader_pin_function_and_clock_out

`default_nettype wire

//--- testbench/host_mcu_model.sv
// Host microcontroller model for the shared pins and data clock
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic [7:0] hostIo,
  input wire logic [7:0] hostIoOe,
  input wire logic [7:0] ioOut,
  input wire logic [7:0] ioOe,
  output logic [7:0] ioIn,
  output logic dataClockPin
);
  logic churn = 1'b0;
  // Released lines wander, so a stale level cannot pass
  always #5 churn = ~churn;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ioIn[i] = ioOe[i] ? ioOut[i] : (hostIoOe[i] ? hostIo[i] : churn);
    end
  end
  initial dataClockPin = 1'b0;
  // Stands low between frames
  task frame(input int n);
    // Off the core clock grid, so the pin never races a sampling edge
    #1;
    repeat (n) begin
      #80 dataClockPin = 1'b1;
      #80 dataClockPin = 1'b0;
    end
  endtask : frame
endmodule : host_mcu_model
`default_nettype wire

//--- testbench/reader_pin_function_and_clock_out_test.sv
// Self-checking bench for the pin function and clock output block
`timescale 1ns/1ps
`default_nettype none
module reader_pin_function_and_clock_out_test;
  import reader_pin_pkg::*;
  logic clock = 0, arst_n = 0, en = 0, en2 = 0, refClk = 0;
  logic modTypeIn = 0, modDataIn = 0, spiMode = 0, directEnable = 0;
  logic directModeOne = 0, modTypeAsOutput = 0, modDataAsOutput = 0;
  logic rxSignal = 0, subcarrierData = 0, decodedBit = 0, bitClock = 0;
  logic spiMiso = 0, parallelDrive = 0;
  logic [1:0] sysClockSetting = 0;
  logic [7:0] parallelOut = 0, hostIo = 0, hostIoOe = 0;
  logic dataClockPin, modTypeOut, modTypeOe, modDataOut, modDataOe, sysClk;
  logic chipActive, powerDownTwo, modulationOok, txKey, spiSelect_n;
  logic spiMosi, dataClockRise, dataClockFall;
  logic [7:0] ioIn, ioOut, ioOe, parallelIn;
  int fails = 0, checkCount = 0;
  always #2 clock = ~clock;
  always #36.875 refClk = ~refClk;
  reader_pin_function_and_clock_out dut (.clock(clock), .arst_n(arst_n),
    .chipEnablePin(en), .secondary_power_select(en2),
    .dataClockPin(dataClockPin), .refClockPin(refClk),
    .modulation_type_select_in(modTypeIn),
    .modulation_type_select_out(modTypeOut),
    .modulation_type_select_oe(modTypeOe),
    .modulation_data_pin_in(modDataIn), .modulation_data_pin_out(modDataOut),
    .modulation_data_pin_oe(modDataOe), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .host_system_clock_out(sysClk), .spiMode(spiMode),
    .directEnable(directEnable), .directModeOne(directModeOne),
    .modTypeAsOutput(modTypeAsOutput), .modDataAsOutput(modDataAsOutput),
    .sysClockSetting(sysClockSetting), .rxSignal(rxSignal),
    .subcarrierData(subcarrierData), .decodedBit(decodedBit),
    .bitClock(bitClock), .spiMiso(spiMiso), .parallelOut(parallelOut),
    .parallelDrive(parallelDrive), .chipActive(chipActive),
    .powerDownTwo(powerDownTwo), .modulationOok(modulationOok),
    .txKey(txKey), .parallelIn(parallelIn), .spiSelect_n(spiSelect_n),
    .spiMosi(spiMosi), .dataClockRise(dataClockRise),
    .dataClockFall(dataClockFall));
  host_mcu_model host (.hostIo(hostIo), .hostIoOe(hostIoOe), .ioOut(ioOut),
    .ioOe(ioOe), .ioIn(ioIn), .dataClockPin(dataClockPin));
  task check(input logic [11:0] seen, input logic [11:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic near(int a, int b, int t);
    return (a - b <= t) && (b - a <= t);
  endfunction : near
  task give_verdict;
    $display("Checks %0d, mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Pin path is five cycles deep; eight leaves margin
  // Inputs move on rising edges; registered outputs read there are settled
  task settle;
    repeat (8) @(posedge clock);
  endtask : settle
  task sleep_test;
    parallelDrive <= 1; modDataAsOutput <= 1; subcarrierData <= 1; settle;
    check(ioOe, 0);
    check(modDataOe, 0);
    check(chipActive, 0);
    check(powerDownTwo, 0);
    check(sysClk, 0);
  endtask : sleep_test
  task parallel_test;
    en <= 1; parallelOut <= 8'hA5; settle;
    check(ioOe, 8'hFF);
    check(ioOut, 8'hA5);
    check(chipActive, 1);
    check({modDataOe, modDataOut}, 2'h3);
    parallelDrive <= 0; hostIo <= 8'h3C; hostIoOe <= 8'hFF;
    modDataAsOutput <= 0; settle;
    check(ioOe, 0);
    check(parallelIn, 8'h3C);
    check(modDataOe, 0);
  endtask : parallel_test
  task spi_test;
    spiMode <= 1; spiMiso <= 1; hostIoOe <= 8'h90; hostIo <= 8'h80; settle;
    check(spiSelect_n, 0);
    check(spiMosi, 1);
    check(ioOe, 8'h40);
    check(ioOut[6], 1);
    hostIo <= 8'h10; settle;
    check(spiSelect_n, 1);
    check(spiMosi, 0);
    check(ioOe, 0);
  endtask : spi_test
  task direct_test;
    for (int m = 0; m < 2; m++) begin
      directEnable <= 1; directModeOne <= m[0]; bitClock <= 1;
      decodedBit <= 1; subcarrierData <= 0; hostIoOe <= 0;
      modTypeIn <= 1; modDataIn <= 1; settle;
      check(ioOe, m ? 8'h60 : 8'h40);
      check(ioOut[6:5], m ? 2'h3 : 2'h0);
      check({modulationOok, txKey, modTypeOe}, 3'h6);
      modTypeIn <= 0; modDataIn <= 0; modTypeAsOutput <= 1; rxSignal <= 1;
      settle;
      check({modulationOok, txKey}, 2'h0);
      check({modTypeOe, modTypeOut}, 2'h3);
      modTypeAsOutput <= 0;
    end
    directEnable <= 0;
  endtask : direct_test
  task dclk_test;
    int r, f;
    r = 0; f = 0;
    fork
      host.frame(5);
      repeat (400) @(posedge clock) begin
        r += dataClockRise;
        f += dataClockFall;
      end
    join
    check(r, 5);
    check(f, 5);
  endtask : dclk_test
  task sysclk_test;
    int rises, refRises, hi, minHigh;
    logic ps, pr;
    for (int s = 0; s < 4; s++) begin
      sysClockSetting <= s[1:0];
      rises = 0; refRises = 0; minHigh = 999; ps = sysClk; pr = refClk;
      hi = sysClk ? 100 : 0;
      repeat (2000) @(posedge clock) begin
        if (sysClk) hi++;
        else if (hi > 0) begin
          if (hi < minHigh) minHigh = hi;
          hi = 0;
        end
        rises += (sysClk && !ps);
        refRises += (refClk && !pr);
        ps = sysClk; pr = refClk;
      end
      check(near(rises, s ? refRises >> (3 - s) : 0, 2), 1);
      check(minHigh >= 4, 1);
      if (s == 0) check(sysClk, 0);
    end
  endtask : sysclk_test
  task slow_test;
    int n;
    en <= 0; en2 <= 1; settle;
    check({powerDownTwo, chipActive}, 2'h2);
    n = 0;
    while (sysClk && n < 5000) begin @(posedge clock); n++; end
    while (!sysClk && n < 10000) begin @(posedge clock); n++; end
    n = 0;
    while (sysClk && n < 5000) begin @(posedge clock); n++; end
    check(near(n, SLOW_HALF_CYCLES, 1), 1);
    en2 <= 0;
    repeat (2200) @(posedge clock);
    check({sysClk, powerDownTwo}, 2'h0);
  endtask : slow_test
  initial begin
    repeat (3) @(posedge clock);
    check({ioOe, sysClk}, 0);
    arst_n <= 1;
    sleep_test; parallel_test; spi_test; direct_test;
    dclk_test; sysclk_test; slow_test;
    give_verdict;
  end
  // Whole run needs about 59 us
  initial begin
    #200us;
    fails++;
    give_verdict;
  end
endmodule : reader_pin_function_and_clock_out_test
`default_nettype wire
